/* inc/msl_pkg.sv */
`default_nettype none
package msl_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned SLOW_PERIOD_MS  = 3000;
    localparam int unsigned FAST_PERIOD_MS  = 1000;
    localparam int unsigned FLASH_ON_MS     = 100;
    localparam int unsigned TICK_US         = 1000;
    // Prescaler: clock cycles per 1 ms tick
    localparam int unsigned TICK_CYCLES     = CLK_HZ / 1_000_000 * TICK_US;
    // Fault code blink timing, in ticks
    localparam int unsigned CODE_ON_MS      = 250;
    localparam int unsigned CODE_OFF_MS     = 250;
    localparam int unsigned CODE_GAP_MS     = 1000;
    localparam int unsigned CODE_REPEATS    = 2;
    localparam int unsigned FAULT_W         = 4;
    // Reset values
    localparam logic        LAMP_RESET      = 1'b0;
endpackage
`default_nettype wire

/* verilog/msl_status_leds.sv */
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Heartbeat flashes once per three seconds
// - Master in config mode: one flash per second
// - Yellow: slave rx frame, master tx frame
// - Slave red: CRC error or illegal request
// - Master red: response timeout or exception reply
// - Green pulses on error-free completion
// - Red solid while restarting
// - After startup, red may blink fault code
// - Slave default; config mode only for master
module msl_status_leds
    import msl_pkg::*;
#(
    parameter int unsigned TICK_DIV  = TICK_CYCLES,
    parameter int unsigned SLOW_MS   = SLOW_PERIOD_MS,
    parameter int unsigned FAST_MS   = FAST_PERIOD_MS,
    parameter int unsigned ON_MS     = FLASH_ON_MS
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               role_master,
    input  wire logic               config_mode,
    input  wire logic               restarting,
    input  wire logic [FAULT_W-1:0] fault_code,
    input  wire logic               frame_rx,
    input  wire logic               frame_tx,
    input  wire logic               crc_error,
    input  wire logic               illegal_req,
    input  wire logic               resp_timeout,
    input  wire logic               exception_rx,
    input  wire logic               good_done,
    output var  logic               led_heartbeat,
    output var  logic               led_yellow,
    output var  logic               led_red,
    output var  logic               led_green
);

    // ==========================================================
    // Elaboration checks
    // Counters other than the 32-bit prescaler, cnt and rep are 16 bits wide and the on-time must fit inside a period,
    // otherwise the heartbeat would never go dark
    if (TICK_DIV < 2 || SLOW_MS <= ON_MS || FAST_MS <= ON_MS || ON_MS == 0 ||
        SLOW_MS >= 65536 || FAST_MS >= 65536) begin : g_bad_timing
        $error("msl_status_leds: unsupported timing parameters");
    end

    // ==========================================================
    // Derived constants
    // Terminal counts are one below the period so a wrap costs no extra tick
    localparam logic [31:0] DIV_LAST  = 32'(TICK_DIV - 1);
    localparam logic [15:0] SLOW_LAST = 16'(SLOW_MS - 1);
    localparam logic [15:0] FAST_LAST = 16'(FAST_MS - 1);
    localparam logic [15:0] ON_TICKS  = 16'(ON_MS);
    localparam logic [15:0] C_ON      = 16'(CODE_ON_MS);
    localparam logic [15:0] C_OFF     = 16'(CODE_OFF_MS);
    localparam logic [15:0] C_GAP     = 16'(CODE_GAP_MS);
    localparam logic [1:0]  C_REP     = 2'(CODE_REPEATS);

    // ==========================================================
    // State
    // Fault player: ON and OFF alternate once per blink, GAP separates
    // repeats of the pattern, IDLE hands red back to the error stretcher
    typedef enum logic [1:0] {CODE_IDLE, CODE_ON, CODE_OFF, CODE_GAP} msl_code_t;

    // pre: prescaler, beat: heartbeat phase in ticks
    // ystr/rstr/gstr: lamp stretchers in ticks
    // ctim/cnt/rep: fault player timer, blinks left, repeats left
    // hb/yl/rd/gr: registered lamp drive, so outputs are glitch free
    typedef struct packed {
        logic [31:0]        pre;
        logic [15:0]        beat;
        logic [15:0]        ystr;
        logic [15:0]        rstr;
        logic [15:0]        gstr;
        msl_code_t          code;
        logic [15:0]        ctim;
        logic [FAULT_W-1:0] cnt;
        logic [1:0]         rep;
        logic               was_restart;
        logic               hb;
        logic               yl;
        logic               rd;
        logic               gr;
    } msl_state_t;

    msl_state_t s;
    msl_state_t next_s;

    // Combinational helpers, recomputed every cycle
    logic tick;
    logic fast;
    logic y_ev;
    logic r_ev;

    // ==========================================================
    // Event decode per role; slave is the default when not master
    // The inactive role's events are ignored, not queued
    // Limitation: no synchroniser, all inputs must come from the clk domain
    always_comb begin
        tick = (s.pre == DIV_LAST);
        fast = role_master && config_mode;
        y_ev = role_master ? frame_tx : frame_rx;
        r_ev = role_master ? (resp_timeout || exception_rx)
                           : (crc_error || illegal_req);
    end

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_s = s;
        // Prescaler, one-cycle tick every millisecond
        next_s.pre = tick ? 32'h0 : s.pre + 32'h1;
        // A level compare rather than a pulse keeps the flash width fixed
        // even when the rate changes in the middle of a period
        // Heartbeat phase counter; wraps early when the rate changes to fast
        if (tick) begin
            if (s.beat >= (fast ? FAST_LAST : SLOW_LAST))
                next_s.beat = 16'h0;
            else
                next_s.beat = s.beat + 16'h1;
        end
        next_s.hb = (s.beat < ON_TICKS);
        // Stretchers: a fresh event reloads, so bursts stay lit
        // On-time is ON_MS-1 to ON_MS ticks plus a cycle or two, depending on tick phase
        if (y_ev)
            next_s.ystr = ON_TICKS;
        else if (tick && s.ystr != 16'h0)
            next_s.ystr = s.ystr - 16'h1;
        if (r_ev)
            next_s.rstr = ON_TICKS;
        else if (tick && s.rstr != 16'h0)
            next_s.rstr = s.rstr - 16'h1;
        if (good_done)
            next_s.gstr = ON_TICKS;
        else if (tick && s.gstr != 16'h0)
            next_s.gstr = s.gstr - 16'h1;
        // The pattern is armed only on the falling edge of restart, so a
        // fault code that changes later does not restart the pattern; a new
        // restart always cancels a pattern still playing
        // Fault code player, armed at the end of a restart
        next_s.was_restart = restarting;
        if (restarting) begin
            next_s.code = CODE_IDLE;
        end else if (s.was_restart && fault_code != '0) begin
            next_s.code = CODE_ON;
            next_s.ctim = C_ON;
            next_s.cnt  = fault_code;
            next_s.rep  = C_REP;
        end else if (tick && s.code != CODE_IDLE) begin
            if (s.ctim > 16'h1) begin
                next_s.ctim = s.ctim - 16'h1;
            end else begin
                unique case (s.code)
                    CODE_ON: begin
                        next_s.code = CODE_OFF;
                        next_s.ctim = C_OFF;
                        next_s.cnt  = s.cnt - 1'b1;
                    end
                    CODE_OFF: begin
                        if (s.cnt != '0) begin
                            next_s.code = CODE_ON;
                            next_s.ctim = C_ON;
                        end else begin
                            next_s.code = CODE_GAP;
                            next_s.ctim = C_GAP;
                        end
                    end
                    CODE_GAP: begin
                        if (s.rep > 2'h1) begin
                            next_s.code = CODE_ON;
                            next_s.ctim = C_ON;
                            next_s.cnt  = fault_code;
                            next_s.rep  = s.rep - 2'h1;
                        end else begin
                            next_s.code = CODE_IDLE;       // back to error lamp
                        end
                    end
                    CODE_IDLE: next_s.code = CODE_IDLE;
                endcase
            end
        end
        // Event lamps light on the edge after the event, not a tick later,
        // so a single short event is not lost unless the fault player holds red
        // Lamp drive; restart overrides everything on red
        next_s.yl = y_ev || (s.ystr != 16'h0);
        next_s.gr = good_done || (s.gstr != 16'h0);
        if (restarting)
            next_s.rd = 1'b1;
        else if (s.code != CODE_IDLE)
            next_s.rd = (s.code == CODE_ON);
        else
            next_s.rd = r_ev || (s.rstr != 16'h0);
    end

    // ==========================================================
    // State register
    // Single asynchronous reset for the whole struct; lamps start dark
    // except the heartbeat, which lights on the first edge after release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s      <= '0;
            s.code <= CODE_IDLE;
            s.hb   <= LAMP_RESET;
        end else begin
            s <= next_s;
        end
    end

    // Outputs come straight from state flops
    // These assigns only rename flops; no logic sits in between
    assign led_heartbeat = s.hb;
    assign led_yellow    = s.yl;
    assign led_red       = s.rd;
    assign led_green     = s.gr;

endmodule // msl_status_leds
`default_nettype wire

/* testbench/msl_leds_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module msl_leds_asserts
    import msl_pkg::*;
#(parameter int unsigned TICK_DIV = 4, parameter int unsigned ON_MS = 2) (
    input wire logic clk, resetn, role_master, config_mode, restarting,
    input wire logic [FAULT_W-1:0] fault_code,
    input wire logic frame_rx, frame_tx, crc_error, illegal_req, resp_timeout, exception_rx, good_done,
    input wire logic led_heartbeat, led_yellow, led_red, led_green
);
    // ==========================================================
    // Cycles since last success event, saturating
    logic [7:0] quiet;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) quiet <= 8'hff;
        else quiet <= good_done ? 8'h00 : quiet + {7'h00, quiet != 8'hff};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_yrx; !role_master && frame_rx |=> led_yellow; endproperty
    a_yrx: assert property (p_yrx) else $error("yellow rx");
    property p_ytx; role_master && frame_tx |=> led_yellow; endproperty
    a_ytx: assert property (p_ytx) else $error("yellow tx");
    property p_yref; !role_master && !frame_rx && !led_yellow |=> !led_yellow; endproperty
    a_yref: assert property (p_yref) else $error("yellow ignored");
    property p_rs; !role_master && !restarting && (crc_error || illegal_req) |=> led_red; endproperty
    a_rs: assert property (p_rs) else $error("red slave");
    property p_rm; role_master && !restarting && (resp_timeout || exception_rx) |=> led_red; endproperty
    a_rm: assert property (p_rm) else $error("red master");
    property p_g; good_done |=> led_green [*3]; endproperty
    a_g: assert property (p_g) else $error("green");
    // Bound is loose by one tick plus two cycles to tolerate tick phase
    property p_off; quiet > ON_MS * TICK_DIV + TICK_DIV + 2 |-> !led_green; endproperty
    a_off: assert property (p_off) else $error("green stuck");
    property p_rst; restarting |=> led_red; endproperty
    a_rst: assert property (p_rst) else $error("red restart");
    property p_hb; $rose(led_heartbeat) |-> led_heartbeat [*7]; endproperty
    a_hb: assert property (p_hb) else $error("heartbeat flash");
    c_fast: cover property (role_master && config_mode && $rose(led_heartbeat));
    c_rst: cover property ($fell(restarting));
    c_two: cover property (good_done ##[1:12] good_done);
endmodule // msl_leds_asserts
bind msl_status_leds msl_leds_asserts #(.TICK_DIV(TICK_DIV), .ON_MS(ON_MS)) chk_u (.*);
`default_nettype wire

/* testbench/msl_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
module msl_engine_model (
    input  wire logic       clk,
    input  wire logic [6:0] req,
    output var  logic [6:0] ev
);
    // ==========================================================
    // One-cycle event strobes, launched just after the edge
    initial ev = 7'h00;
    always @(posedge clk) ev <= #1 req;
endmodule // msl_engine_model
`default_nettype wire

/* testbench/msl_status_leds_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module msl_status_leds_tb;
    import msl_pkg::*;
    localparam int TD = 4, SL = 30, FA = 10, ON = 2;
    logic clk = 0, resetn = 0, role = 0, cfg = 0, rst_in = 0, hb, yel, red, grn;
    logic [6:0] req = 7'h00, ev;
    logic [FAULT_W-1:0] fc = '0;
    int err_count = 0, n_compared = 0, seed = 90687, cyc = 0, k, m;
    time t0;
    msl_engine_model eng_u (.clk(clk), .req(req), .ev(ev));
    msl_status_leds #(.TICK_DIV(TD), .SLOW_MS(SL), .FAST_MS(FA), .ON_MS(ON)) dut_u (.clk(clk), .resetn(resetn),
        .role_master(role), .config_mode(cfg), .restarting(rst_in), .fault_code(fc),
        .frame_rx(ev[0]), .frame_tx(ev[1]), .crc_error(ev[2]), .illegal_req(ev[3]), .resp_timeout(ev[4]),
        .exception_rx(ev[5]), .good_done(ev[6]), .led_heartbeat(hb), .led_yellow(yel), .led_red(red),
        .led_green(grn));
    // ==========================================================
    // Clock and hang guard
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 6000) begin err_count++; stop_test(); end
    end
    // Expected {yellow, red, green}; a lamp of the other role stays dark
    function automatic logic [2:0] lamps(int k, int m);
        lamps = 3'h0;
        if (k == m) lamps = 3'h4;
        if (k == 2 + 2 * m || k == 3 + 2 * m) lamps = 3'h2;
        if (k == 6) lamps = 3'h1;
    endfunction
    task automatic stop_test();
        if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp_l(string nm, logic [2:0] e, logic [2:0] s);
        n_compared++;
        if (s !== e) begin err_count++; $display("CHECK FAILED %s expected %h seen %h", nm, e, s); end
    endtask
    task automatic cmp_p(string nm, int e, int s);
        n_compared++;
        if (s != e) begin err_count++; $display("CHECK FAILED %s expected %0d seen %0d", nm, e, s); end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(int k);
        req = 7'h01 << k;
        step(1);
        req = 7'h00;
    endtask
    // Second full period, since a rate switch may cut the first short
    task automatic period(logic r, logic c, int e);
        role = r;
        cfg = c;
        repeat (2) @(posedge hb);
        t0 = $time;
        @(posedge hb);
        cmp_p("heartbeat period", e, int'(($time - t0) / 10));
        step(1);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        step(5);
        resetn = 1;
        period(0, 1, SL * TD);
        period(1, 0, SL * TD);
        period(1, 1, FA * TD);
        for (m = 0; m < 2; m++) for (k = 0; k < 7; k++) begin
            role = m[0];
            cfg = 1'($random(seed));
            pulse(k);
            step(2);
            cmp_l("event lamps", lamps(k, m), {yel, red, grn});
            step(20);
            cmp_l("lamps after stretch", 3'h0, {yel, red, grn});
        end
        pulse(6);
        step(8);
        pulse(6);
        step(4);
        cmp_l("retriggered green", 3'h1, {yel, red, grn});
        rst_in = 1;
        step(3);
        cmp_l("red while restarting", 3'h2, {yel, red, grn});
        rst_in = 0;
        step(3);
        cmp_l("red after restart", 3'h0, {yel, red, grn});
        // Nonzero fault code: first blink lit for 250 ticks, then dark
        fc = FAULT_W'(1 + ($random(seed) & 3));
        rst_in = 1;
        step(3);
        rst_in = 0;
        step(500);
        cmp_l("fault code lit", 3'h2, {yel, red, grn});
        step(1000);
        cmp_l("fault code dark", 3'h0, {yel, red, grn});
        rst_in = 1;
        step(3);
        cmp_l("red over fault code", 3'h2, {yel, red, grn});
        fc = '0;
        rst_in = 0;
        step(3);
        cmp_l("fault code cancelled", 3'h0, {yel, red, grn});
        stop_test();
    end
endmodule // msl_status_leds_tb
`default_nettype wire
